//--- src/twu_params.svh
// Register map, field positions, reset values and status codes of the two-wire unit
`ifndef TWU_PARAMS_SVH
`define TWU_PARAMS_SVH
`define TWU_OFF_CONTROL 8'h00
`define TWU_OFF_STATUS  8'h04
`define TWU_OFF_DATA    8'h08
`define TWU_OFF_RATE    8'h0c
`define TWU_CTL_STEP    7
`define TWU_CTL_ACKEN   6
`define TWU_CTL_STA     5
`define TWU_CTL_STO     4
`define TWU_CTL_WCOL    3
`define TWU_CTL_EN      2
`define TWU_CTL_IE      0
`define TWU_RST_RATE    8'h09
`define TWU_RST_DATA    8'hff
`define TWU_SC_START    8'h08
`define TWU_SC_RSTART   8'h10
`define TWU_SC_AW_ACK   8'h18
`define TWU_SC_AW_NACK  8'h20
`define TWU_SC_TX_ACK   8'h28
`define TWU_SC_TX_NACK  8'h30
`define TWU_SC_ARB      8'h38
`define TWU_SC_AR_ACK   8'h40
`define TWU_SC_AR_NACK  8'h48
`define TWU_SC_RX_ACK   8'h50
`define TWU_SC_RX_NACK  8'h58
`define TWU_SC_IDLE     8'hf8
`endif

//--- src/twu_pkg.sv
// Types shared by the two-wire unit modules
package twu_pkg;
  typedef enum logic [3:0] {
    TWU_E_IDLE  = 4'b0001,
    TWU_E_START = 4'b0010,
    TWU_E_STOP  = 4'b0100,
    TWU_E_BIT   = 4'b1000
  } twu_eng_st_type;
  typedef enum logic [3:0] {
    TWU_T_IDLE = 4'b0001,
    TWU_T_HOLD = 4'b0010,
    TWU_T_FREE = 4'b0100,
    TWU_T_RUN  = 4'b1000
  } twu_top_st_type;
  typedef enum logic [2:0] {
    TWU_OP_START, TWU_OP_STOP, TWU_OP_ADDR, TWU_OP_TX, TWU_OP_RX
  } twu_op_type;
  typedef enum logic [2:0] {
    TWU_CMD_NONE, TWU_CMD_START, TWU_CMD_STOP, TWU_CMD_WRITE, TWU_CMD_READ
  } twu_cmd_type;
  typedef struct packed {
    logic        go;
    twu_cmd_type cmd;
    logic [7:0]  data;
    logic        nack;
  } twu_eng_req_type;
  typedef struct packed {
    logic       done;
    logic       arb;
    logic       nack;
    logic [7:0] rx;
    logic       busy;
    logic       own;
  } twu_eng_rsp_type;
  typedef struct packed {
    twu_eng_st_type st;
    logic [1:0]     ph;
    logic [7:0]     cnt;
    logic [3:0]     bitn;
    logic [8:0]     shift;
    logic [7:0]     rx;
    logic           rd;
    logic           own;
    logic           scl_low;
    logic           sda_low;
    logic           busy;
    logic           scl_q;
    logic           sda_q;
    logic           done;
    logic           arb;
    logic           nack;
  } twu_eng_state_type;
  typedef struct packed {
    twu_top_st_type  st;
    twu_op_type      op;
    logic            flag;
    logic            ack_en;
    logic            sta;
    logic            sto;
    logic            wcol;
    logic            en;
    logic            ie;
    logic [7:0]      code;
    logic [1:0]      presc;
    logic [7:0]      data;
    logic [7:0]      rate;
    logic            rx_mode;
    logic            then_start;
    logic            ack_sent;
    twu_eng_req_type ereq;
    logic            wb_ack;
    logic [31:0]     wb_dat;
  } twu_top_state_type;
endpackage

//--- src/twu_sync.sv
// Two-flop synchroniser for the two-wire pin inputs
`timescale 1ns/1ps
module twu_sync #(
  parameter int WIDTH = 2
) (
  // System
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Lines
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } twu_sync_state_type;
  twu_sync_state_type s;
  twu_sync_state_type next_s;
  always_comb begin
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end
  // Idle bus lines are high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end
  assign sync_out = s.stable;
endmodule // twu_sync

//--- src/twu_engine.sv
// Bit engine: START, STOP and nine-bit byte slots on the two-wire bus
`timescale 1ns/1ps
module twu_engine
  import twu_pkg::*;
(
  // System
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [7:0] quarter,
  // Command and answer
  input  twu_pkg::twu_eng_req_type req,
  output twu_pkg::twu_eng_rsp_type rsp,
  // Synchronised lines and drive enables
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output logic            scl_oe,
  output logic            sda_oe
);
  import twu_pkg::*;
  twu_eng_state_type s;
  twu_eng_state_type next_s;
  logic tick;
  logic stretched;
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.arb = 1'b0;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    // START and STOP seen on the bus, ours or another master's
    if (s.scl_q && scl_s && s.sda_q && !sda_s) begin
      next_s.busy = 1'b1;
    end else if (s.scl_q && scl_s && !s.sda_q && sda_s) begin
      next_s.busy = 1'b0;
    end
    // A slave holding the clock low freezes the phase timer
    stretched = !s.scl_low && !scl_s && (s.st != TWU_E_IDLE);
    tick = (s.cnt == quarter) && !stretched;
    next_s.cnt = (tick || stretched || s.st == TWU_E_IDLE) ? 8'h00 : 8'(s.cnt + 8'd1);
    if (tick) begin
      next_s.ph = 2'(s.ph + 2'd1);
    end
    unique case (s.st)
      TWU_E_IDLE: begin
        next_s.ph = 2'd0;
        if (req.go && req.cmd == TWU_CMD_START) begin
          next_s.st = TWU_E_START;
        end else if (req.go && req.cmd == TWU_CMD_STOP) begin
          next_s.st = TWU_E_STOP;
        end else if (req.go && (req.cmd == TWU_CMD_WRITE || req.cmd == TWU_CMD_READ)) begin
          next_s.st = TWU_E_BIT;
          next_s.rd = (req.cmd == TWU_CMD_READ);
          next_s.bitn = 4'd0;
          next_s.shift = (req.cmd == TWU_CMD_READ) ? {8'hff, req.nack} : {req.data, 1'b1};
        end
      end
      TWU_E_START: begin
        if (tick) begin
          unique case (s.ph)
            2'd0: next_s.sda_low = 1'b0;
            2'd1: next_s.scl_low = 1'b0;
            2'd2: next_s.sda_low = 1'b1;
            2'd3: begin
              next_s.scl_low = 1'b1;
              next_s.own = 1'b1;
              next_s.done = 1'b1;
              next_s.st = TWU_E_IDLE;
            end
          endcase
        end
      end
      TWU_E_STOP: begin
        if (tick) begin
          unique case (s.ph)
            2'd0: next_s.sda_low = 1'b1;
            2'd1: next_s.scl_low = 1'b0;
            default: begin
              next_s.sda_low = 1'b0;
              next_s.own = 1'b0;
              next_s.done = 1'b1;
              next_s.st = TWU_E_IDLE;
            end
          endcase
        end
      end
      TWU_E_BIT: begin
        if (tick) begin
          unique case (s.ph)
            2'd0: next_s.sda_low = !s.shift[8];
            2'd1: next_s.scl_low = 1'b0;
            2'd2: begin
              if (s.bitn != 4'd8 && s.rd) begin
                next_s.rx = {s.rx[6:0], sda_s};
              end
              if (s.bitn == 4'd8 && !s.rd) begin
                next_s.nack = sda_s;
              end
              // Released a one but the line reads low: another master won
              if (s.shift[8] && !sda_s && (s.rd == (s.bitn == 4'd8))) begin
                next_s.arb = 1'b1;
                next_s.done = 1'b1;
                next_s.own = 1'b0;
                next_s.sda_low = 1'b0;
                next_s.st = TWU_E_IDLE;
              end
            end
            2'd3: begin
              next_s.scl_low = 1'b1;
              next_s.shift = {s.shift[7:0], 1'b1};
              next_s.bitn = 4'(s.bitn + 4'd1);
              if (s.bitn == 4'd8) begin
                next_s.done = 1'b1;
                next_s.st = TWU_E_IDLE;
              end
            end
          endcase
        end
      end
    endcase
    // Disabled unit lets go of both lines
    if (!enable) begin
      next_s.st = TWU_E_IDLE;
      next_s.own = 1'b0;
      next_s.scl_low = 1'b0;
      next_s.sda_low = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: TWU_E_IDLE, shift: 9'h1ff, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end
  assign scl_oe = s.scl_low;
  assign sda_oe = s.sda_low;
  assign rsp = '{done: s.done, arb: s.arb, nack: s.nack, rx: s.rx, busy: s.busy, own: s.own};
endmodule // twu_engine

//--- src/twu_top.sv
// Two-wire unit: Wishbone registers and byte-level master sequencer
// Summary of operation
// - Master transmit and receive run here; otherwise the unit idles unaddressed.
// - Bus transfer waits while step flag set; status code names the bus state.
// - A requested START waits until the bus is free.
// - After START goes out the step flag sets with code 0x08.
// - Address read/write bit selects master transmit or master receive.
// - After address with write: flag with 0x18, 0x20 or 0x38.
// - Data writes with flag low are discarded and set write collision.
// - Repeated START reports 0x10 and keeps the bus.
// - In 0x08 or 0x10 the loaded address goes out with its acknowledge.
// - After each sent byte: flag with 0x28 on ack, 0x30 on nack.
// - In 0x18-0x30: data, repeated START, STOP, or STOP then START.
// - Stop request clears itself once the STOP has gone out.
// - Arbitration loss reports 0x38; then release or START when free.
// - Writing one to step clears it; enable must be set to operate.
// - No step flag after a STOP.
// - Clock line held low while the step flag is set and the bus is owned.
`timescale 1ns/1ps
`include "twu_params.svh"
module twu_top
  import twu_pkg::*;
(
  // System
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Two-wire bus, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Interrupt
  input  wire logic        irq_global_en,
  output logic             step_irq
);
  import twu_pkg::*;

  twu_top_state_type s;
  twu_top_state_type next_s;
  twu_eng_rsp_type   rsp;
  logic [1:0]        lines_s;
  logic              access;
  logic              wr;
  logic              go;
  logic [7:0]        wbyte;
  logic [7:0]        rd_byte;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  function automatic logic is_mt_code(input logic [7:0] c);
    is_mt_code = (c == `TWU_SC_AW_ACK) || (c == `TWU_SC_AW_NACK)
              || (c == `TWU_SC_TX_ACK) || (c == `TWU_SC_TX_NACK);
  endfunction

  twu_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({scl_i, sda_i}),
    .sync_out (lines_s)
  );

  twu_engine u_engine (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .enable  (s.en),
    .quarter (s.rate),
    .req     (s.ereq),
    .rsp     (rsp),
    .scl_s   (lines_s[1]),
    .sda_s   (lines_s[0]),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe)
  );

  // Register read view
  always_comb begin
    rd_byte = 8'h00;
    if (hit(wb_adr_i, `TWU_OFF_CONTROL)) begin
      rd_byte = {s.flag, s.ack_en, s.sta, s.sto, s.wcol, s.en, 1'b0, s.ie};
    end else if (hit(wb_adr_i, `TWU_OFF_STATUS)) begin
      rd_byte = {s.code[7:3], 1'b0, s.presc};
    end else if (hit(wb_adr_i, `TWU_OFF_DATA)) begin
      rd_byte = s.data;
    end else if (hit(wb_adr_i, `TWU_OFF_RATE)) begin
      rd_byte = s.rate;
    end
  end

  always_comb begin
    next_s = s;
    next_s.ereq.go = 1'b0;
    access = wb_cyc_i && wb_stb_i && !s.wb_ack;
    wr = access && wb_we_i && wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    go = 1'b0;
    next_s.wb_ack = access;
    if (access && !wb_we_i) begin
      next_s.wb_dat = {24'h000000, rd_byte};
    end

    // Control register write
    if (wr && hit(wb_adr_i, `TWU_OFF_CONTROL)) begin
      next_s.ack_en = wbyte[`TWU_CTL_ACKEN];
      next_s.sta = wbyte[`TWU_CTL_STA];
      next_s.sto = wbyte[`TWU_CTL_STO];
      next_s.en = wbyte[`TWU_CTL_EN];
      next_s.ie = wbyte[`TWU_CTL_IE];
      if (wbyte[`TWU_CTL_STEP]) begin
        next_s.flag = 1'b0;
      end
      go = wbyte[`TWU_CTL_STEP] && wbyte[`TWU_CTL_EN]
        && (s.st == TWU_T_IDLE || s.st == TWU_T_HOLD);
    end
    if (wr && hit(wb_adr_i, `TWU_OFF_STATUS)) begin
      next_s.presc = wbyte[1:0];
    end
    if (wr && hit(wb_adr_i, `TWU_OFF_DATA)) begin
      if (s.flag) begin
        next_s.data = wbyte;
        next_s.wcol = 1'b0;
      end else begin
        next_s.wcol = 1'b1;
      end
    end
    if (wr && hit(wb_adr_i, `TWU_OFF_RATE)) begin
      next_s.rate = wbyte;
    end

    // Software has answered: choose the next bus action
    // Master modes sequenced here
    if (go) begin
      next_s.st = TWU_T_IDLE;
      next_s.code = `TWU_SC_IDLE;
      if (wbyte[`TWU_CTL_STO] && rsp.own) begin
        next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_STOP, data: s.data, nack: 1'b1};
        next_s.op = TWU_OP_STOP;
        next_s.then_start = wbyte[`TWU_CTL_STA];
        next_s.st = TWU_T_RUN;
        next_s.code = s.code;
      end else if (wbyte[`TWU_CTL_STA] && rsp.own) begin
        next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_START, data: s.data, nack: 1'b1};
        next_s.op = TWU_OP_START;
        next_s.st = TWU_T_RUN;
        next_s.code = s.code;
      end else if (wbyte[`TWU_CTL_STA]) begin
        next_s.st = TWU_T_FREE;
      end else if (wbyte[`TWU_CTL_STO]) begin
        // Nothing to stop without the bus
        next_s.sto = 1'b0;
      end else if (s.code == `TWU_SC_START || s.code == `TWU_SC_RSTART) begin
        next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_WRITE, data: s.data, nack: 1'b1};
        next_s.op = TWU_OP_ADDR;
        next_s.rx_mode = s.data[0];
        next_s.st = TWU_T_RUN;
        next_s.code = s.code;
      end else if (is_mt_code(s.code)) begin
        next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_WRITE, data: s.data, nack: 1'b1};
        next_s.op = TWU_OP_TX;
        next_s.st = TWU_T_RUN;
        next_s.code = s.code;
      end else if (s.code == `TWU_SC_AR_ACK || s.code == `TWU_SC_RX_ACK) begin
        next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_READ, data: s.data, nack: !wbyte[`TWU_CTL_ACKEN]};
        next_s.op = TWU_OP_RX;
        next_s.ack_sent = wbyte[`TWU_CTL_ACKEN];
        next_s.st = TWU_T_RUN;
        next_s.code = s.code;
      end
    end

    unique case (s.st)
      TWU_T_IDLE: begin
      end
      TWU_T_HOLD: begin
      end
      TWU_T_FREE: begin
        if (!rsp.busy) begin
          next_s.ereq = '{go: 1'b1, cmd: TWU_CMD_START, data: s.data, nack: 1'b1};
          next_s.op = TWU_OP_START;
          next_s.st = TWU_T_RUN;
        end
      end
      TWU_T_RUN: begin
        if (rsp.done) begin
          // Set wins over a clear in the same cycle
          next_s.flag = 1'b1;
          next_s.st = TWU_T_HOLD;
          unique case (s.op)
            TWU_OP_START: begin
              next_s.code = (s.code == `TWU_SC_IDLE || s.code == `TWU_SC_ARB)
                ? `TWU_SC_START : `TWU_SC_RSTART;
            end
            TWU_OP_STOP: begin
              next_s.sto = 1'b0;
              next_s.flag = s.flag;
              next_s.code = `TWU_SC_IDLE;
              next_s.st = s.then_start ? TWU_T_FREE : TWU_T_IDLE;
            end
            TWU_OP_ADDR: begin
              if (s.rx_mode) begin
                next_s.code = rsp.nack ? `TWU_SC_AR_NACK : `TWU_SC_AR_ACK;
              end else begin
                next_s.code = rsp.nack ? `TWU_SC_AW_NACK : `TWU_SC_AW_ACK;
              end
            end
            TWU_OP_TX: begin
              next_s.code = rsp.nack ? `TWU_SC_TX_NACK : `TWU_SC_TX_ACK;
            end
            TWU_OP_RX: begin
              next_s.data = rsp.rx;
              next_s.code = s.ack_sent ? `TWU_SC_RX_ACK : `TWU_SC_RX_NACK;
            end
            default: begin
              next_s.code = `TWU_SC_IDLE;
            end
          endcase
          if (rsp.arb) begin
            next_s.code = `TWU_SC_ARB;
            next_s.flag = 1'b1;
            next_s.st = TWU_T_HOLD;
          end
        end
      end
    endcase

    if (!next_s.en) begin
      next_s.st = TWU_T_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{
        st:    TWU_T_IDLE,
        op:    TWU_OP_START,
        code:  `TWU_SC_IDLE,
        data:  `TWU_RST_DATA,
        rate:  `TWU_RST_RATE,
        default: '0
      };
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.wb_dat;
  assign wb_ack_o = s.wb_ack;
  // Open drain: only the enables ever change
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  // Engine keeps clock low while it owns the bus and waits
  assign step_irq = s.flag && s.ie && irq_global_en;
endmodule // twu_top

//--- tb/twu_checker.sv
// Port-level assertions for the two-wire unit
`timescale 1ns/1ps
module twu_checker (
  // System
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Lines and interrupt
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq_global_en,
  input wire logic        step_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long software pause cannot wrap it
  logic [7:0] flag_age;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) flag_age <= 8'h00;
    else if (!step_irq) flag_age <= 8'h00;
    else if (flag_age != 8'hff) flag_age <= flag_age + 8'h01;
  end
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_high_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_flag_holds: assert property (step_irq && !(wb_cyc_i && wb_we_i)
    |=> step_irq || !irq_global_en) else $error("step flag dropped without a write");
  a_clock_stretched: assert property (flag_age > 8'h28 |-> scl_oe)
    else $error("clock line free while flag stands");
  a_irq_gated: assert property (!irq_global_en |-> !step_irq)
    else $error("interrupt without global enable");
  a_no_flag_stop: assert property ($fell(sda_oe) && !scl_oe && scl_i
    |=> !step_irq [*2]) else $error("step flag after stop");
  c_flag_set: cover property ($rose(step_irq));
  c_stop_sent: cover property ($fell(sda_oe) && !scl_oe && scl_i);
  c_long_hold: cover property (flag_age == 8'h29);
endmodule // twu_checker
bind twu_top twu_checker u_checker (
  .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .irq_global_en(irq_global_en), .step_irq(step_irq)
);

//--- tb/twu_slave_model.sv
// Slave receiver on the two-wire bus: acks or nacks, may stretch the clock
`timescale 1ns/1ps
module twu_slave_model (
  // Bus levels and pulls
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull,
  // Behaviour
  input  wire logic nack_all,
  input  wire logic stretch,
  // Observed traffic
  output logic [7:0] last_byte,
  output int         n_starts,
  output int         n_stops
);
  int         bitn = 0;
  logic [7:0] shift = 8'h00;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    last_byte = 8'h00;
    n_starts = 0;
    n_stops = 0;
  end
  always @(negedge sda) if (scl) begin
    n_starts++;
    bitn = 0;
  end
  always @(posedge sda) if (scl) n_stops++;
  always @(posedge scl) if (bitn < 8) begin
    shift = {shift[6:0], sda};
    bitn++;
  end
  // Ack slot driven from the falling clock so data never moves while it is high
  always @(negedge scl) begin
    if (bitn == 8) begin
      last_byte = shift;
      sda_pull = !nack_all;
      bitn = 9;
      // Stretch before the ack slot so the master's phase timer must wait
      if (stretch) begin
        scl_pull = 1'b1;
        #400;
        scl_pull = 1'b0;
      end
    end else if (bitn == 9) begin
      sda_pull = 1'b0;
      bitn = 0;
    end
  end
endmodule // twu_slave_model

//--- tb/twu_top_bench.sv
// Self-checking bench of the two-wire unit as master transmitter
`timescale 1ns/1ps
`include "twu_params.svh"
module twu_top_bench;
  localparam logic [7:0] CTL = `TWU_OFF_CONTROL;
  localparam logic [7:0] STS = `TWU_OFF_STATUS;
  localparam logic [7:0] DAT = `TWU_OFF_DATA;
  localparam logic [7:0] RATE = `TWU_OFF_RATE;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic        glob = 1'b1;
  logic        nack_all = 1'b0;
  logic        stretch = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, scl_oe, sda_oe, scl_pull, sda_pull, irq;
  logic [7:0]  last_byte;
  int          n_starts, n_stops, n_errors = 0, samples_checked = 0, k;
  // Open-drain lines with pull-ups
  wire         scl_w = !(scl_oe || scl_pull);
  wire         sda_w = !(sda_oe || sda_pull);
  always #4 mclk = ~mclk;
  twu_top dut (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
    .irq_global_en(glob), .step_irq(irq)
  );
  twu_slave_model slave (
    .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull), .nack_all(nack_all),
    .stretch(stretch), .last_byte(last_byte), .n_starts(n_starts), .n_stops(n_stops)
  );
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("wb_ack", 32'h1, {31'h0, ack});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // Write control, poll for the flag, compare the status code
  task automatic step(input logic [7:0] ctl, input logic [7:0] code);
    int n;
    wr(CTL, ctl);
    n = 0;
    do begin
      rd(CTL);
      n++;
    end while (q[7] !== 1'b1 && n < 300);
    chk("step_flag", 32'h80, q & 32'h80);
    rd(STS);
    chk("status", {24'h0, code}, q);
  endtask
  task automatic t_regs();
    rd(CTL);
    chk("control", 32'h0, q);
    rd(STS);
    chk("status", {24'h0, `TWU_SC_IDLE}, q);
    rd(DAT);
    chk("data", {24'h0, `TWU_RST_DATA}, q);
    rd(8'h10);
    chk("unmapped", 32'h0, q);
    sel <= 4'h0;
    wr(RATE, 8'h55);
    sel <= 4'hf;
    rd(RATE);
    chk("rate", {24'h0, `TWU_RST_RATE}, q);
    // Quarter of two cycles gives a bit time near the link rate
    wr(RATE, 8'h01);
    rd(RATE);
    chk("rate", 32'h1, q);
  endtask
  task automatic t_collision();
    wr(DAT, 8'h5a);
    rd(CTL);
    chk("collision", 32'h08, q);
    rd(DAT);
    chk("data kept", {24'h0, `TWU_RST_DATA}, q);
  endtask
  task automatic t_transmit();
    step(8'ha5, `TWU_SC_START);
    chk("step_irq", 32'h1, {31'h0, irq});
    glob <= 1'b0;
    @(posedge mclk);
    chk("step_irq masked", 32'h0, {31'h0, irq});
    glob <= 1'b1;
    wr(DAT, 8'ha4);
    wr(CTL, 8'h05);
    rd(CTL);
    chk("held flag", 32'h80, q & 32'h80);
    chk("collision cleared", 32'h0, q & 32'h08);
    step(8'h85, `TWU_SC_AW_ACK);
    chk("address", 32'ha4, {24'h0, last_byte});
    wr(DAT, 8'h3c);
    stretch <= 1'b1;
    step(8'h85, `TWU_SC_TX_ACK);
    stretch <= 1'b0;
    chk("byte", 32'h3c, {24'h0, last_byte});
    nack_all <= 1'b1;
    wr(DAT, 8'hc3);
    step(8'h85, `TWU_SC_TX_NACK);
    k = n_starts;
    step(8'ha5, `TWU_SC_RSTART);
    chk("starts", k + 1, n_starts);
    wr(DAT, 8'ha4);
    step(8'h85, `TWU_SC_AW_NACK);
    nack_all <= 1'b0;
    k = n_stops;
    step(8'hb5, `TWU_SC_START);
    chk("stops", k + 1, n_stops);
    wr(DAT, 8'ha4);
    step(8'h85, `TWU_SC_AW_ACK);
    wr(CTL, 8'h95);
    k = 0;
    do begin
      rd(CTL);
      k++;
    end while (q[4] !== 1'b0 && k < 200);
    chk("control after stop", 32'h05, q);
    rd(STS);
    chk("status idle", {24'h0, `TWU_SC_IDLE}, q);
  endtask
  task automatic t_disable();
    step(8'ha5, `TWU_SC_START);
    wr(CTL, 8'h80);
    rd(CTL);
    chk("control", 32'h0, q);
    chk("lines", 32'h0, {30'h0, scl_oe, sda_oe});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog fails the run after fifty thousand cycles
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_collision();
    t_transmit();
    t_disable();
    complete_run();
  end
endmodule // twu_top_bench
